// File: design/touch_sensor_power_state_ctrl.sv
// power-state controller of the touch sensor
`timescale 1ns/1ps
`default_nettype none
// Contract
// - two request bits pick one of three states
// - state change clears touches of inactive channels
// - active: sample enabled inputs, leds as configured
// - standby: sample chosen channels, serve bus
// - deep sleep: no sampling, leds static idle
// - traffic wakes deep sleep temporarily
// - wake pin high in deep sleep clears deep sleep request except in four-wire spi
// - companion link: deep sleep request ignored
// - reset pin high holds everything in reset
// - reset restores defaults, clears readings
// - reset release sets reset status, interrupt
// - four-wire spi: wake pin never driven
// - standby touch drives wake until int cleared or standby left
// - interrupt sets pending flag, alert follows it
module touch_sensor_power_state_ctrl (
    input  wire logic       clk,           // system clock
    input  wire logic       rstn,          // power-on reset, active low
    input  wire logic       reset_pin,     // external reset, active high
    input  wire logic [1:0] if_mode,       // serial link mode
    input  wire logic       standby_request_bit_set,      // host writes standby bit 1
    input  wire logic       standby_request_bit_clr,      // host writes standby bit 0
    input  wire logic       dsl_set,       // host writes deep sleep bit 1
    input  wire logic       dsl_clr,       // host writes deep sleep bit 0
    input  wire logic       int_clr,       // host clears pending flag
    input  wire logic       rst_stat_clr,  // host clears reset status
    input  wire logic [5:0] ch_en_wr,      // new active channel mask
    input  wire logic       ch_en_we,      // write strobe for ch_en_wr
    input  wire logic [5:0] sb_en_wr,      // new standby channel mask
    input  wire logic       sb_en_we,      // write strobe for sb_en_wr
    input  wire logic [5:0] led_idle_wr,   // new led idle levels
    input  wire logic       led_idle_we,   // write strobe for led_idle_wr
    input  wire logic [5:0] touch_in,      // touch events, one-cycle
    input  wire logic [5:0] led_pat,       // led pattern from led engine
    input  wire logic       serial_act,    // traffic addressed to device
    input  wire logic       wake_in,       // wake pin input level
    output logic            wake_out,      // wake pin drive value
    output logic            wake_oe,       // wake pin output enable
    output logic [5:0]      sample_en,     // channels to sample
    output logic [5:0]      led_out,       // led drive values
    output logic            led_oe,        // leds driven
    output logic            pwm_en,        // pwm engine allowed
    output logic [5:0]      touch_stat,    // touch status bits
    output logic            int_pend,      // interrupt pending flag
    output logic            alert,         // alert output, active high
    output logic            rst_stat,      // reset status bit
    output logic            standby_request_bit_bit,      // standby request bit
    output logic            dsl_bit,       // deep sleep request bit
    output logic [2:0]      pstate,        // current power state
    output logic            serial_rst     // serial interface held reset
);
    pwr_if pi ();

    pin_sync u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .wake_in (wake_in),
        .act_in  (serial_act),
        .p       (pi)
    );

    quiet_timer u_tmr (
        .clk  (clk),
        .rstn (rstn),
        .p    (pi)
    );

    // ------------------------------------------------------------------
    // reset pin synchroniser
    // ------------------------------------------------------------------
    logic rp1_q;
    logic rp2_q;
    logic rp_prev_q;
    logic rp1_d;
    logic rp2_d;
    logic rp_prev_d;

    always_comb begin
        rp1_d = reset_pin;
        rp2_d = rp1_q;
        rp_prev_d = rp2_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rp1_q <= 1'b1;
            rp2_q <= 1'b1;
            rp_prev_q <= 1'b1;
        end else begin
            rp1_q <= rp1_d;
            rp2_q <= rp2_d;
            rp_prev_q <= rp_prev_d;
        end
    end

    logic in_rst;
    logic rst_rel;
    assign in_rst = rp2_q;
    assign rst_rel = rp_prev_q & ~rp2_q;

    // target state from the two request bits
    function automatic pwr_pkg::pstate_type pick_state(
        input logic sb,
        input logic ds
    );
        if (ds) begin
            pick_state = pwr_pkg::ST_DEEP;
        end else if (sb) begin
            pick_state = pwr_pkg::ST_STANDBY;
        end else begin
            pick_state = pwr_pkg::ST_ACTIVE;
        end
    endfunction

    // ------------------------------------------------------------------
    // control and power state
    // ------------------------------------------------------------------
    pwr_pkg::pstate_type st_q;
    pwr_pkg::pstate_type st_d;
    logic       standby_request_bit_q, standby_request_bit_d;
    logic       dsl_q, dsl_d;
    logic       intp_q, intp_d;
    logic       rsts_q, rsts_d;
    logic [5:0] tst_q, tst_d;
    logic [5:0] chen_q, chen_d;
    logic [5:0] sben_q, sben_d;
    logic [5:0] idle_q, idle_d;
    logic       wk_q, wk_d;
    logic [1:0] drv_q, drv_d;   // standby drive history of the wake pin

    logic spi4;
    logic comp;
    logic [5:0] act_mask;
    logic [5:0] hits;
    assign spi4 = (if_mode == pwr_pkg::IF_SPI4);
    assign comp = (if_mode == pwr_pkg::IF_COMPANION);

    always_comb begin
        standby_request_bit_d = standby_request_bit_q;
        dsl_d = dsl_q;
        intp_d = intp_q;
        rsts_d = rsts_q;
        tst_d = tst_q;
        chen_d = chen_q;
        sben_d = sben_q;
        idle_d = idle_q;
        wk_d = wk_q;
        st_d = st_q;
        // wake pin level stays ours for two sync stages after driving it
        drv_d = {drv_q[0], st_q == pwr_pkg::ST_STANDBY};
        act_mask = 6'h00;
        hits = 6'h00;
        if (in_rst) begin
            // defaults restored, readings cleared, held asleep
            standby_request_bit_d = 1'b0;
            dsl_d = 1'b0;
            intp_d = 1'b0;
            rsts_d = 1'b0;
            tst_d = 6'h00;
            chen_d = pwr_pkg::CH_EN_RST;
            sben_d = pwr_pkg::SB_EN_RST;
            idle_d = pwr_pkg::LED_IDLE_RST;
            wk_d = 1'b0;
            st_d = pwr_pkg::ST_DEEP;
        end else begin
            // host bit writes
            if (standby_request_bit_set) standby_request_bit_d = 1'b1;
            if (standby_request_bit_clr) standby_request_bit_d = 1'b0;
            if (dsl_set && !comp) dsl_d = 1'b1;
            if (dsl_clr) dsl_d = 1'b0;
            if (comp) dsl_d = 1'b0;
            if (ch_en_we) chen_d = ch_en_wr;
            if (sb_en_we) sben_d = sb_en_wr;
            if (led_idle_we) idle_d = led_idle_wr;
            // external wake clears deep sleep request
            // our own standby drive may still sit in the synchroniser
            if (st_q == pwr_pkg::ST_DEEP && !spi4 && pi.wake_raw
                && drv_q == 2'h0) begin
                dsl_d = 1'b0;
            end
            // touches of sampled channels only
            case (st_q)
                pwr_pkg::ST_ACTIVE: act_mask = chen_q;
                pwr_pkg::ST_STANDBY: act_mask = sben_q;
                pwr_pkg::ST_DEEP: act_mask = 6'h00;
                default: act_mask = 6'h00;
            endcase
            hits = touch_in & act_mask;
            // clear wins only without a new event
            if (int_clr) intp_d = 1'b0;
            if (int_clr) tst_d = 6'h00;
            tst_d = tst_d | hits;
            if (hits != 6'h00) intp_d = 1'b1;
            if (rst_stat_clr) rsts_d = 1'b0;
            if (rst_rel) begin
                rsts_d = 1'b1;
                intp_d = 1'b1;
            end
            // wake pin drive in standby
            if (st_q == pwr_pkg::ST_STANDBY && !spi4 && hits != 6'h00) begin
                wk_d = 1'b1;
            end
            if (!intp_d || st_q != pwr_pkg::ST_STANDBY || spi4) begin
                wk_d = 1'b0;
            end
            // state follows bits; traffic holds device awake
            st_d = pick_state(standby_request_bit_d, dsl_d);
            if (st_d == pwr_pkg::ST_DEEP && pi.awake) begin
                st_d = standby_request_bit_d ? pwr_pkg::ST_STANDBY : pwr_pkg::ST_ACTIVE;
            end
            // transitions drop touches of channels now inactive
            if (st_d != st_q) begin
                case (st_d)
                    pwr_pkg::ST_ACTIVE: tst_d = tst_d & chen_d;
                    pwr_pkg::ST_STANDBY: tst_d = tst_d & sben_d;
                    pwr_pkg::ST_DEEP: tst_d = 6'h00;
                    default: tst_d = 6'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= pwr_pkg::ST_DEEP;
            standby_request_bit_q <= 1'b0;
            dsl_q <= 1'b0;
            intp_q <= 1'b0;
            rsts_q <= 1'b0;
            tst_q <= 6'h00;
            chen_q <= pwr_pkg::CH_EN_RST;
            sben_q <= pwr_pkg::SB_EN_RST;
            idle_q <= pwr_pkg::LED_IDLE_RST;
            wk_q <= 1'b0;
            drv_q <= 2'h0;
        end else begin
            st_q <= st_d;
            standby_request_bit_q <= standby_request_bit_d;
            dsl_q <= dsl_d;
            intp_q <= intp_d;
            rsts_q <= rsts_d;
            tst_q <= tst_d;
            chen_q <= chen_d;
            sben_q <= sben_d;
            idle_q <= idle_d;
            wk_q <= wk_d;
            drv_q <= drv_d;
        end
    end

    // ------------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------------
    logic [5:0] samp_q, samp_d;
    logic [5:0] led_q, led_d;
    logic       ledoe_q, ledoe_d;
    logic       pwm_q, pwm_d;
    logic       woe_q, woe_d;
    logic       srst_q, srst_d;

    always_comb begin
        samp_d = 6'h00;
        led_d = idle_d;
        ledoe_d = 1'b0;
        pwm_d = 1'b0;
        srst_d = in_rst;
        woe_d = 1'b0;
        if (!in_rst) begin
            ledoe_d = 1'b1;
            case (st_d)
                pwr_pkg::ST_ACTIVE: begin
                    samp_d = chen_d;
                    led_d = led_pat;
                    pwm_d = 1'b1;
                end
                pwr_pkg::ST_STANDBY: begin
                    samp_d = sben_d;
                    led_d = led_pat;
                    pwm_d = 1'b1;
                end
                pwr_pkg::ST_DEEP: begin
                    samp_d = 6'h00;
                    led_d = idle_d;
                end
                default: samp_d = 6'h00;
            endcase
            // never drive in spi4 nor deep sleep
            woe_d = !spi4 && st_d == pwr_pkg::ST_STANDBY;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp_q <= 6'h00;
            led_q <= 6'h00;
            ledoe_q <= 1'b0;
            pwm_q <= 1'b0;
            woe_q <= 1'b0;
            srst_q <= 1'b1;
        end else begin
            samp_q <= samp_d;
            led_q <= led_d;
            ledoe_q <= ledoe_d;
            pwm_q <= pwm_d;
            woe_q <= woe_d;
            srst_q <= srst_d;
        end
    end

    assign wake_out = wk_q;
    assign wake_oe = woe_q;
    assign sample_en = samp_q;
    assign led_out = led_q;
    assign led_oe = ledoe_q;
    assign pwm_en = pwm_q;
    assign touch_stat = tst_q;
    assign int_pend = intp_q;
    assign alert = intp_q;
    assign rst_stat = rsts_q;
    assign standby_request_bit_bit = standby_request_bit_q;
    assign dsl_bit = dsl_q;
    assign pstate = st_q;
    assign serial_rst = srst_q;
endmodule
`default_nettype wire

// File: design/pwr_pkg.sv
// shared constants and types of the power-state controller
`default_nettype none
package pwr_pkg;
    localparam int unsigned NCH = 6;                // sensor / led channels
    localparam logic [5:0]  CH_EN_RST = 6'h3F;      // all channels enabled
    localparam logic [5:0]  SB_EN_RST = 6'h01;      // standby samples ch1
    localparam logic [5:0]  LED_IDLE_RST = 6'h00;   // non-actuated level
    // serial activity must stay quiet this long before deep sleep returns
    localparam int unsigned QUIET_NS = 1000;
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned QUIET_CYC = QUIET_NS / CLK_NS;
    localparam logic [7:0]  QUIET_CNT = 8'(QUIET_CYC);
    localparam logic [7:0]  QUIET_RST = 8'h00;

    // power states, one-hot
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_STANDBY = 3'b010,
        ST_DEEP = 3'b100
    } pstate_type;

    // serial link modes
    typedef enum logic [1:0] {
        IF_SMBUS = 2'h0,
        IF_SPI4 = 2'h1,
        IF_SPI3 = 2'h2,
        IF_COMPANION = 2'h3
    } ifmode_type;
endpackage
`default_nettype wire

// File: design/pwr_if.sv
// signals passed between the power controller and its helpers
`timescale 1ns/1ps
`default_nettype none
interface pwr_if;
    logic       wake_raw;    // synchronised wake pin level
    logic       act_raw;     // synchronised serial activity
    logic       awake;       // serial traffic holds device awake
    modport ctrl (input wake_raw, input act_raw, input awake);
    modport sync (output wake_raw, output act_raw);
    modport tmr (input act_raw, output awake);
endinterface
`default_nettype wire

// File: design/pin_sync.sv
// two-flop synchronisers for wake pin and serial activity
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic clk,        // system clock
    input  wire logic rstn,       // async reset, active low
    input  wire logic wake_in,    // wake pin input level
    input  wire logic act_in,     // serial traffic addressed to device
    pwr_if.sync       p           // synchronised outputs
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s1_d;
    logic [1:0] s2_d;

    // first stage feeds only the second
    always_comb begin
        s1_d = {act_in, wake_in};
        s2_d = s1_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign p.wake_raw = s2_q[0];
    assign p.act_raw = s2_q[1];
endmodule
`default_nettype wire

// File: design/quiet_timer.sv
// keeps device awake until serial traffic has been quiet a while
`timescale 1ns/1ps
`default_nettype none
module quiet_timer (
    input  wire logic clk,        // system clock
    input  wire logic rstn,       // async reset, active low
    pwr_if.tmr        p           // activity in, awake out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // reload on activity, count down when quiet
    always_comb begin
        cnt_d = cnt_q;
        if (p.act_raw) begin
            cnt_d = pwr_pkg::QUIET_CNT;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= pwr_pkg::QUIET_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign p.awake = p.act_raw | (cnt_q != 8'h00);
endmodule
`default_nettype wire

// File: verification/touch_sensor_power_state_ctrl_sva.sv
// assertions on the power-state controller ports
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_power_state_ctrl_sva (
    input wire logic       clk,        // system clock
    input wire logic       rstn,       // reset, active low
    input wire logic [1:0] if_mode,    // link mode
    input wire logic       int_clr,    // pending clear
    input wire logic [5:0] touch_in,   // touch events
    input wire logic       serial_act, // serial traffic
    input wire logic       wake_in,    // wake pin level
    input wire logic       wake_out,   // wake pin value
    input wire logic       wake_oe,    // wake pin enable
    input wire logic [5:0] sample_en,  // sampled channels
    input wire logic       led_oe,     // leds driven
    input wire logic       pwm_en,     // pwm allowed
    input wire logic [5:0] touch_stat, // touch status
    input wire logic       int_pend,   // pending flag
    input wire logic       alert,      // alert output
    input wire logic       rst_stat,   // reset status
    input wire logic       standby_request_bit_bit,   // standby request
    input wire logic       dsl_bit,    // deep sleep request
    input wire logic [2:0] pstate,     // power state
    input wire logic       serial_rst  // serial reset
);
    // ---------------------------------------------
    // power state checks
    // ---------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_state_select: assert property (!serial_rst && !$past(serial_rst)
        && !dsl_bit |-> pstate == (standby_request_bit_bit ? 3'h2 : 3'h1))
        else $error("state does not follow request bits");
    a_deep_wins: assert property ($rose(dsl_bit) |-> pstate == 3'h4)
        else $error("deep sleep request not taken");
    a_clear_inactive: assert property ($changed(pstate) && !serial_rst
        |-> (touch_stat & ~sample_en) == 6'h00)
        else $error("inactive touch kept over state change");
    a_deep_quiet: assert property (pstate == 3'h4
        |-> sample_en == 6'h00 && !pwm_en)
        else $error("sampling or pwm in deep sleep");
    a_traffic_wake: assert property ($rose(serial_act) && pstate == 3'h4
        && !serial_rst |-> ##[1:6] pstate != 3'h4)
        else $error("traffic did not wake device");
    a_wake_pin: assert property ($rose(wake_in) && pstate == 3'h4
        && if_mode != 2'h1 |-> ##[1:5] !dsl_bit && pstate == 3'h1)
        else $error("wake pin did not wake device");
    a_companion_deep: assert property (if_mode == 2'h3 && !dsl_bit
        |=> !dsl_bit)
        else $error("deep sleep taken in companion mode");
    a_reset_hold: assert property (serial_rst
        |-> pstate == 3'h4 && !led_oe && sample_en == 6'h00)
        else $error("device active while reset held");
    a_reset_flag: assert property ($fell(serial_rst)
        |-> ##[0:2] rst_stat && int_pend)
        else $error("reset release not flagged");
    a_spi4_input: assert property (if_mode == 2'h1
        && $past(if_mode) == 2'h1 |-> !wake_oe)
        else $error("wake pin driven in four-wire mode");
    a_wake_touch: assert property (pstate == 3'h2 && if_mode != 2'h1
        && (touch_in & sample_en) != 6'h00 |=> wake_out && wake_oe)
        else $error("standby touch did not raise wake");
    a_wake_release: assert property (wake_out && int_clr
        && touch_in == 6'h00 |=> !wake_out)
        else $error("wake kept after pending clear");
    a_alert_follows: assert property (alert == int_pend)
        else $error("alert differs from pending flag");
endmodule

bind touch_sensor_power_state_ctrl touch_sensor_power_state_ctrl_sva sva (
    .clk, .rstn, .if_mode, .int_clr, .touch_in, .serial_act, .wake_in,
    .wake_out, .wake_oe, .sample_en, .led_oe, .pwm_en, .touch_stat,
    .int_pend, .alert, .rst_stat, .standby_request_bit_bit, .dsl_bit, .pstate, .serial_rst
);
`default_nettype wire

// File: verification/host_side.sv
// host controller side of the shared wake pin
`timescale 1ns/1ps
`default_nettype none
module host_side (
    input  wire logic wake_out,  // device drive value
    input  wire logic wake_oe,   // device drives the pin
    input  wire logic host_wake, // host pulls the pin high
    output logic      wake_pin   // resolved pin level
);
    // device drive first, then the host, else the pull-down
    always_comb begin
        if (wake_oe)
            wake_pin = wake_out;
        else if (host_wake)
            wake_pin = 1'b1;
        else
            wake_pin = 1'b0;
    end
endmodule
`default_nettype wire

// File: verification/touch_sensor_power_state_ctrl_tb.sv
// self-checking bench of the power-state controller
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_power_state_ctrl_tb;
    logic       clk, rstn, reset_pin, serial_act, host_wake, wake_pin;
    logic [1:0] if_mode;
    logic [9:0] strb;       // one strobe per host operation
    logic [5:0] dat;        // mask data or touched channels
    logic       wake_out, wake_oe, led_oe, pwm_en, int_pend, alert;
    logic       rst_stat, standby_request_bit_bit, dsl_bit, serial_rst;
    logic [5:0] sample_en, led_out, touch_stat;
    logic [2:0] pstate;
    int         errors, compares;

    touch_sensor_power_state_ctrl dut (
        .clk, .rstn, .reset_pin, .if_mode, .standby_request_bit_set(strb[0]),
        .standby_request_bit_clr(strb[1]), .dsl_set(strb[2]), .dsl_clr(strb[3]),
        .int_clr(strb[4]), .rst_stat_clr(strb[5]), .ch_en_wr(dat),
        .ch_en_we(strb[6]), .sb_en_wr(dat), .sb_en_we(strb[7]),
        .led_idle_wr(dat), .led_idle_we(strb[8]),
        .touch_in(strb[9] ? dat : 6'h00), .led_pat(6'h15), .serial_act,
        .wake_in(wake_pin), .wake_out, .wake_oe, .sample_en, .led_out,
        .led_oe, .pwm_en, .touch_stat, .int_pend, .alert, .rst_stat,
        .standby_request_bit_bit, .dsl_bit, .pstate, .serial_rst
    );
    host_side host (.wake_out, .wake_oe, .host_wake, .wake_pin);

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // print the verdict and stop
    task automatic conclude;
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one host operation: strobe k for one cycle with data d
    task automatic op(input int k, input logic [5:0] d);
        @(posedge clk);
        #1;
        strb[k] = 1'b1;
        dat = d;
        @(posedge clk);
        #1;
        strb = 10'h000;
    endtask

    // wait for state st, or for serial reset to drop when st is 0
    task automatic wait_st(input logic [2:0] st);
        int i;
        for (i = 0; i < 400; i++) begin
            if (st == 3'h0 ? serial_rst === 1'b0 : pstate === st)
                break;
            @(posedge clk);
            #1;
        end
        if (i == 400) begin
            errors++;
            conclude();
        end
    endtask

    // reset release, then one scenario after another
    initial begin
        rstn = 1'b0;
        reset_pin = 1'b0;
        if_mode = 2'h0;
        strb = 10'h000;
        dat = 6'h00;
        serial_act = 1'b0;
        host_wake = 1'b0;
        errors = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int r = 0; r < 2; r++) begin
            wait_st(3'h0);
            @(posedge clk);
            #1;
            chk(rst_stat, 8'h01);
            chk(alert, 8'h01);
            chk(standby_request_bit_bit, 8'h00);
            chk(pstate, pwr_pkg::ST_ACTIVE);
            chk(sample_en, pwr_pkg::CH_EN_RST);
            chk({led_oe, pwm_en}, 8'h03);
            op(4, 6'h00);
            op(5, 6'h00);
            chk(int_pend, 8'h00);
            chk(rst_stat, 8'h00);
            if (r == 1)
                break;
            // active touch on a channel that standby drops
            op(6, 6'h05);
            chk(sample_en, 8'h05);
            chk(led_out, 8'h15);
            op(9, 6'h04);
            chk(touch_stat, 8'h04);
            op(0, 6'h00);
            chk(pstate, pwr_pkg::ST_STANDBY);
            chk(touch_stat, 8'h00);
            chk(sample_en, pwr_pkg::SB_EN_RST);
            op(4, 6'h00);
            // standby touches, unsampled then sampled
            op(9, 6'h02);
            chk(wake_out, 8'h00);
            op(9, 6'h01);
            chk({wake_oe, wake_out, touch_stat}, 8'hC1);
            chk(int_pend, 8'h01);
            op(4, 6'h00);
            chk({wake_out, alert}, 8'h00);
            op(1, 6'h00);
            chk(pstate, pwr_pkg::ST_ACTIVE);
            // deep sleep with idle levels, three-wire link
            if_mode = 2'h2;
            op(8, 6'h2A);
            op(2, 6'h00);
            chk(pstate, pwr_pkg::ST_DEEP);
            chk({pwm_en, wake_oe, sample_en}, 8'h00);
            chk(led_out, 8'h2A);
            serial_act = 1'b1;
            wait_st(pwr_pkg::ST_ACTIVE);
            chk(dsl_bit, 8'h01);
            serial_act = 1'b0;
            repeat (100) @(posedge clk);
            #1;
            chk(pstate, pwr_pkg::ST_ACTIVE);
            wait_st(pwr_pkg::ST_DEEP);
            host_wake = 1'b1;
            wait_st(pwr_pkg::ST_ACTIVE);
            chk(dsl_bit, 8'h00);
            host_wake = 1'b0;
            // both request bits, standby wake still raised
            op(0, 6'h00);
            op(9, 6'h01);
            op(2, 6'h00);
            chk(pstate, pwr_pkg::ST_DEEP);
            repeat (4) @(posedge clk);
            #1;
            chk({dsl_bit, pstate}, 8'h0C);
            op(4, 6'h00);
            op(3, 6'h00);
            chk(pstate, pwr_pkg::ST_STANDBY);
            op(1, 6'h00);
            // companion link refuses deep sleep
            if_mode = 2'h3;
            op(2, 6'h00);
            chk({dsl_bit, pstate}, 8'h01);
            // four-wire link never drives the wake pin
            if_mode = 2'h1;
            op(0, 6'h00);
            op(9, 6'h01);
            chk({wake_oe, int_pend}, 8'h01);
            op(4, 6'h00);
            op(1, 6'h00);
            if_mode = 2'h0;
            // external reset in mid-run
            op(7, 6'h03);
            reset_pin = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            chk({serial_rst, led_oe, pstate}, 8'h14);
            chk(sample_en, 8'h00);
            op(0, 6'h00);
            reset_pin = 1'b0;
        end
        op(0, 6'h00);
        chk(sample_en, pwr_pkg::SB_EN_RST);
        conclude();
    end
endmodule
`default_nettype wire
